//--- crsq_pkg.sv
package crsq_pkg;

	// Clock gear codes; values above the slowest setting are reserved.
	localparam logic [2:0] GEAR_DIV16 = 3'h4;
	localparam logic [2:0] GEAR_RESET = GEAR_DIV16;

	localparam logic [23:0] VEC_BASE = 24'hffff00;
	localparam logic [31:0] SP_RESET = 32'h0000_0100;
	localparam logic [2:0] MASK_RESET = 3'h7;
	localparam logic MAX_RESET = 1'b1;
	localparam logic [2:0] BANK_RESET = 3'h0;
	localparam logic [23:0] PC_RESET = 24'h000000;

	// Least low time of the reset pin, counted in system ticks.
	localparam logic [3:0] MIN_LOW_TICKS = 4'ha;

	localparam logic [1:0] VEC_BYTES_LAST = 2'h2;

	localparam logic [7:0] OFS_GEAR = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_PC = 8'h08;
	localparam logic [7:0] OFS_SP = 8'h0c;

	localparam int STATUS_STATE_LSB = 0;
	localparam int STATUS_CNT_LSB = 4;
	localparam int STATUS_MASK_LSB = 8;
	localparam int STATUS_MAX_BIT = 11;
	localparam int STATUS_BANK_LSB = 12;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_HOLD = 3'b001,
		ST_VEC = 3'b010,
		ST_READY = 3'b011,
		ST_RUN = 3'b100
	} crsq_state_t;

endpackage

//--- crsq_cpu_reset_init_sequencer.sv
`timescale 1ns/1ps

// How it works
// R1 - External circuit holds reset pin low at least 10 system ticks, supplies stable.
// R2 - Accepted reset forces clock gear to divide-by-16, system tick at fc/32.
// R3 - Program counter loads from vector bytes ffff00, ffff01, ffff02, low byte first.
// R4 - Accepted reset loads system stack pointer with 100h.
// R5 - Accepted reset sets interrupt mask level to 111.
// R6 - Accepted reset sets the wide-address mode flag to one.
// R7 - Accepted reset clears register bank pointer to zero.
// R8 - After release the core starts fetching at the loaded program counter.
// R9 - Reset leaves RAM and all other core registers untouched.
// R10 - Accepted reset returns peripheral control registers to initial values.
// R11 - Accepted reset puts every port pin into general-purpose port mode.
// R12 - Accepted reset floats the address latch strobe pin.
// R13 - Pin is synchronised, init held while low, core released first edge after.
module crsq_cpu_reset_init_sequencer (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic reset_pin_n_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_we_i,
	input wire logic reg_re_i,
	output logic [31:0] reg_rdata_o,
	output logic [23:0] mem_addr_o,
	output logic mem_rd_o,
	input wire logic [7:0] mem_data_i,
	output logic system_tick_o,
	output logic [2:0] clock_gear_o,
	output logic [23:0] program_counter_o,
	output logic [31:0] system_stack_pointer_o,
	output logic [2:0] interrupt_mask_level_o,
	output logic max_mode_o,
	output logic [2:0] register_bank_pointer_o,
	output logic core_run_o,
	output logic fetch_start_o,
	output logic periph_init_o,
	output logic port_mode_init_o,
	output logic ale_oe_o
);

	crsq_pkg::crsq_state_t state_reg;
	crsq_pkg::crsq_state_t state_next;
	logic pin_meta_reg;
	logic pin_sync_reg;
	logic [4:0] div_reg;
	logic [4:0] div_limit;
	logic tick;
	logic [2:0] gear_reg;
	logic [3:0] low_cnt_reg;
	logic low_done;
	logic ran_reg;
	logic [1:0] vec_idx_reg;
	logic vec_phase_reg;
	logic [23:0] pc_reg;
	logic [31:0] sp_reg;
	logic [2:0] mask_reg;
	logic max_reg;
	logic [2:0] bank_reg;
	logic fetch_reg;
	logic [31:0] rdata_reg;

	// The pin is a Schmitt input from outside the clock domain.
	// Both flops reset to the pin's idle high level, so no false low follows reset.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_meta_reg <= 1'b1;
			pin_sync_reg <= 1'b1;
		end else begin
			pin_meta_reg <= reset_pin_n_i; // R13
			pin_sync_reg <= pin_meta_reg; // R13
		end
	end

	// System tick period is two oscillator cycles times the gear divisor.
	always_comb begin
		case (gear_reg)
			3'h0: div_limit = 5'h01;
			3'h1: div_limit = 5'h03;
			3'h2: div_limit = 5'h07;
			3'h3: div_limit = 5'h0f;
			default: div_limit = 5'h1f;
		endcase
	end

	assign tick = (div_reg >= div_limit);

	always_ff @(posedge clk_i) begin
		if (rst_i || tick) begin
			div_reg <= 5'h00;
		end else begin
			div_reg <= div_reg + 5'h01;
		end
	end

	// Reserved gear codes are refused so the tick never runs out of range.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			gear_reg <= crsq_pkg::GEAR_RESET;
		end else if (state_reg == crsq_pkg::ST_VEC || state_reg == crsq_pkg::ST_READY) begin
			gear_reg <= crsq_pkg::GEAR_DIV16; // R2
		end else if (reg_we_i && reg_addr_i == crsq_pkg::OFS_GEAR && reg_wdata_i[2:0] <= crsq_pkg::GEAR_DIV16) begin
			gear_reg <= reg_wdata_i[2:0];
		end
	end

	// Low time is measured in system ticks while the pin stays low.
	always_ff @(posedge clk_i) begin
		if (rst_i || pin_sync_reg) begin
			low_cnt_reg <= 4'h0;
		end else if (tick && !low_done) begin
			low_cnt_reg <= low_cnt_reg + 4'h1;
		end
	end

	assign low_done = (low_cnt_reg >= crsq_pkg::MIN_LOW_TICKS); // R1

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			crsq_pkg::ST_IDLE: begin
				if (!pin_sync_reg) begin
					state_next = crsq_pkg::ST_HOLD;
				end
			end
			crsq_pkg::ST_RUN: begin
				if (!pin_sync_reg) begin
					state_next = crsq_pkg::ST_HOLD; // R13
				end
			end
			crsq_pkg::ST_HOLD: begin
				if (pin_sync_reg) begin
					state_next = ran_reg ? crsq_pkg::ST_RUN : crsq_pkg::ST_IDLE;
				end else if (low_done) begin
					state_next = crsq_pkg::ST_VEC; // R1
				end
			end
			crsq_pkg::ST_VEC: begin
				if (vec_phase_reg && vec_idx_reg == crsq_pkg::VEC_BYTES_LAST) begin
					// A pin already released skips the wait in READY.
					state_next = pin_sync_reg ? crsq_pkg::ST_RUN : crsq_pkg::ST_READY; // R13
				end
			end
			crsq_pkg::ST_READY: begin
				if (pin_sync_reg) begin
					state_next = crsq_pkg::ST_RUN; // R13
				end
			end
			default: begin
				state_next = crsq_pkg::ST_IDLE;
			end
		endcase
	end

	// A pulse released while the vector is being read is finished anyway, so the
	// core never starts from a half-loaded program counter.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_reg <= crsq_pkg::ST_HOLD;
		end else begin
			state_reg <= state_next;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ran_reg <= 1'b0;
		end else if (state_reg == crsq_pkg::ST_RUN) begin
			ran_reg <= 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || state_reg != crsq_pkg::ST_VEC) begin
			vec_idx_reg <= 2'h0;
			vec_phase_reg <= 1'b0;
		end else begin
			vec_phase_reg <= !vec_phase_reg;
			if (vec_phase_reg) begin
				vec_idx_reg <= vec_idx_reg + 2'h1;
			end
		end
	end

	assign mem_rd_o = (state_reg == crsq_pkg::ST_VEC) && !vec_phase_reg;
	assign mem_addr_o = crsq_pkg::VEC_BASE + {22'h0, vec_idx_reg}; // R3

	// Only the counter, flags word fields and stack pointer are written here.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pc_reg <= crsq_pkg::PC_RESET;
		end else if (state_reg == crsq_pkg::ST_VEC && vec_phase_reg) begin
			case (vec_idx_reg)
				2'h0: pc_reg[7:0] <= mem_data_i; // R3
				2'h1: pc_reg[15:8] <= mem_data_i; // R3
				default: pc_reg[23:16] <= mem_data_i; // R3
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || state_reg == crsq_pkg::ST_VEC) begin // R9
			sp_reg <= crsq_pkg::SP_RESET; // R4
			mask_reg <= crsq_pkg::MASK_RESET; // R5
			max_reg <= crsq_pkg::MAX_RESET; // R6
			bank_reg <= crsq_pkg::BANK_RESET; // R7
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fetch_reg <= 1'b0;
		end else begin
			fetch_reg <= (state_next == crsq_pkg::ST_RUN) && (state_reg != crsq_pkg::ST_RUN); // R8
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdata_reg <= 32'h0000_0000;
		end else if (reg_re_i) begin
			if (reg_addr_i == crsq_pkg::OFS_GEAR) begin
				rdata_reg <= {29'h0, gear_reg};
			end else if (reg_addr_i == crsq_pkg::OFS_STATUS) begin
				rdata_reg <= {17'h0, bank_reg, max_reg, mask_reg, low_cnt_reg, 1'b0, state_reg};
			end else if (reg_addr_i == crsq_pkg::OFS_PC) begin
				rdata_reg <= {8'h00, pc_reg};
			end else if (reg_addr_i == crsq_pkg::OFS_SP) begin
				rdata_reg <= sp_reg;
			end else begin
				rdata_reg <= 32'h0000_0000;
			end
		end
	end

	assign reg_rdata_o = rdata_reg;
	assign system_tick_o = tick;
	assign clock_gear_o = gear_reg;
	assign program_counter_o = pc_reg;
	assign system_stack_pointer_o = sp_reg;
	assign interrupt_mask_level_o = mask_reg;
	assign max_mode_o = max_reg;
	assign register_bank_pointer_o = bank_reg;
	assign core_run_o = (state_reg == crsq_pkg::ST_RUN); // R8
	assign fetch_start_o = fetch_reg;
	assign periph_init_o = (state_reg == crsq_pkg::ST_VEC) || (state_reg == crsq_pkg::ST_READY); // R10
	assign port_mode_init_o = periph_init_o; // R11
	// Strobe output enable is low while initialising, leaving the pin floating.
	assign ale_oe_o = core_run_o; // R12

	property p_gear_div16;
		@(posedge clk_i) disable iff (rst_i)
		(state_reg == crsq_pkg::ST_VEC) |=> (gear_reg == 3'h4) && (div_limit == 5'h1f);
	endproperty
	a_gear_div16: assert property (p_gear_div16) else $error("gear not forced to div16"); // R2

	property p_vec_addr;
		@(posedge clk_i) disable iff (rst_i)
		mem_rd_o |-> (mem_addr_o == 24'hffff00 + {22'h0, vec_idx_reg}) && (mem_addr_o[23:2] == 22'h3fffc0);
	endproperty
	a_vec_addr: assert property (p_vec_addr) else $error("vector address wrong"); // R3

	property p_pc_hi;
		@(posedge clk_i) disable iff (rst_i)
		(state_reg == crsq_pkg::ST_VEC && vec_phase_reg && vec_idx_reg == 2'h2) |=>
			(pc_reg[23:16] == $past(mem_data_i));
	endproperty
	a_pc_hi: assert property (p_pc_hi) else $error("upper pc byte not loaded"); // R3

	property p_cpu_init;
		@(posedge clk_i) disable iff (rst_i)
		(state_reg == crsq_pkg::ST_READY) |->
			(sp_reg == 32'h100) && (mask_reg == 3'h7) && max_reg && (bank_reg == 3'h0);
	endproperty
	a_cpu_init: assert property (p_cpu_init) else $error("core registers not initialised"); // R4 R5 R6 R7

	property p_release;
		@(posedge clk_i) disable iff (rst_i)
		(state_reg == crsq_pkg::ST_READY && pin_sync_reg) |=> core_run_o && fetch_start_o ##1 !fetch_start_o;
	endproperty
	a_release: assert property (p_release) else $error("core not released after reset"); // R8

	property p_pc_kept;
		@(posedge clk_i) disable iff (rst_i)
		(core_run_o && $past(core_run_o)) |-> $stable(pc_reg) && $stable(sp_reg);
	endproperty
	a_pc_kept: assert property (p_pc_kept) else $error("core register changed while running"); // R9

	property p_init_float;
		@(posedge clk_i) disable iff (rst_i)
		(state_reg == crsq_pkg::ST_VEC) |-> periph_init_o && port_mode_init_o && !ale_oe_o;
	endproperty
	a_init_float: assert property (p_init_float) else $error("peripherals or strobe not reset"); // R10

	property p_ports;
		@(posedge clk_i) disable iff (rst_i)
		(state_reg == crsq_pkg::ST_READY) [*2] |-> port_mode_init_o;
	endproperty
	a_ports: assert property (p_ports) else $error("ports left in peripheral mode"); // R11

	property p_ale;
		@(posedge clk_i) disable iff (rst_i)
		!core_run_o |-> !ale_oe_o;
	endproperty
	a_ale: assert property (p_ale) else $error("strobe driven while in reset"); // R12

	property p_enter_hold;
		@(posedge clk_i) disable iff (rst_i)
		(core_run_o && !pin_sync_reg) |=> (state_reg == crsq_pkg::ST_HOLD) && !core_run_o;
	endproperty
	a_enter_hold: assert property (p_enter_hold) else $error("reset pin low not taken"); // R13

	property p_no_early;
		@(posedge clk_i) disable iff (rst_i)
		(state_reg == crsq_pkg::ST_HOLD && !low_done) |=> (state_reg != crsq_pkg::ST_VEC);
	endproperty
	a_no_early: assert property (p_no_early) else $error("reset accepted before least low time"); // R1

	property p_short_keep;
		@(posedge clk_i) disable iff (rst_i)
		(state_reg == crsq_pkg::ST_HOLD && pin_sync_reg && ran_reg) |=>
			core_run_o && $stable(pc_reg) && $stable(sp_reg);
	endproperty
	a_short_keep: assert property (p_short_keep) else $error("short pulse changed core state"); // R13

	property p_vec_single;
		@(posedge clk_i) disable iff (rst_i)
		mem_rd_o |=> !mem_rd_o && (state_reg == crsq_pkg::ST_VEC);
	endproperty
	a_vec_single: assert property (p_vec_single) else $error("vector byte not captured"); // R3

	c_full_reset: cover property (@(posedge clk_i) disable iff (rst_i)
		state_reg == crsq_pkg::ST_READY ##[1:100] fetch_start_o);
	c_short_pulse: cover property (@(posedge clk_i) disable iff (rst_i)
		state_reg == crsq_pkg::ST_HOLD ##1 state_reg == crsq_pkg::ST_RUN);
	c_gear_write: cover property (@(posedge clk_i) disable iff (rst_i)
		reg_we_i && reg_addr_i == crsq_pkg::OFS_GEAR ##1 gear_reg == 3'h0);
	c_late_release: cover property (@(posedge clk_i) disable iff (rst_i)
		state_reg == crsq_pkg::ST_VEC ##1 state_reg == crsq_pkg::ST_RUN);
	c_reserved_write: cover property (@(posedge clk_i) disable iff (rst_i)
		reg_we_i && reg_addr_i == crsq_pkg::OFS_GEAR && reg_wdata_i[2:0] > crsq_pkg::GEAR_DIV16);

endmodule

//--- crsq_reset_src.sv
`timescale 1ns/1ps
module crsq_reset_src #(
	parameter logic [23:0] VEC = 24'h5a3c81
) (
	input wire logic clk_i,
	input wire logic pulse_i,
	input wire logic [15:0] len_i,
	input wire logic [23:0] addr_i,
	input wire logic rd_i,
	output logic reset_pin_n_o,
	output logic [7:0] data_o
);
	logic [15:0] cnt_reg = 16'h0000;
	// The caller chooses the low time, so a short pulse can be tried too.
	always @(posedge clk_i) begin
		if (pulse_i) cnt_reg <= len_i;
		else if (cnt_reg != 16'h0000) cnt_reg <= cnt_reg - 16'h0001;
	end
	assign reset_pin_n_o = (cnt_reg == 16'h0000);
	// Outside a read the byte toggles, so a stale sample never looks right.
	always @(posedge clk_i) begin
		if (rd_i) data_o <= VEC[8*addr_i[1:0] +: 8];
		else data_o <= ~data_o;
	end
endmodule

//--- crsq_cpu_reset_init_sequencer_tb.sv
`timescale 1ns/1ps
module crsq_cpu_reset_init_sequencer_tb;
	localparam logic [23:0] VEC = 24'h5a3c81;
	logic clk_i, rst_i, pin_n, pulse, we, re, rd, ph, pm, run, fst, ale, mx, tick;
	logic [15:0] len;
	logic [7:0] addr, md;
	logic [31:0] wdata, rdata, sp;
	logic [23:0] maddr, pc;
	logic [2:0] gear, mask, bank;
	logic [7:0] r_a [5];
	logic [31:0] r_m [5];
	logic [31:0] r_e [5];
	int err_count = 0;
	int n_tests = 0;
	int i;

	crsq_cpu_reset_init_sequencer u_dut (.clk_i(clk_i), .rst_i(rst_i), .reset_pin_n_i(pin_n),
		.reg_addr_i(addr), .reg_wdata_i(wdata), .reg_we_i(we), .reg_re_i(re), .reg_rdata_o(rdata),
		.mem_addr_o(maddr), .mem_rd_o(rd), .mem_data_i(md), .system_tick_o(tick), .clock_gear_o(gear),
		.program_counter_o(pc), .system_stack_pointer_o(sp), .interrupt_mask_level_o(mask),
		.max_mode_o(mx), .register_bank_pointer_o(bank), .core_run_o(run), .fetch_start_o(fst),
		.periph_init_o(ph), .port_mode_init_o(pm), .ale_oe_o(ale));

	crsq_reset_src #(.VEC(VEC)) u_src (.clk_i(clk_i), .pulse_i(pulse), .len_i(len),
		.addr_i(maddr), .rd_i(rd), .reset_pin_n_o(pin_n), .data_o(md));

	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	task stop_test;
		$display("checks %0d, mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask

	task chk(input logic [31:0] g, input logic [31:0] e, input string m);
		n_tests++;
		if (g !== e) begin
			err_count++;
			$display("wrong value at %0t: %s got %h want %h", $time, m, g, e);
		end
	endtask

	task rd_chk(input logic [7:0] a, input logic [31:0] k, input logic [31:0] e);
		@(posedge clk_i);
		addr <= a;
		re <= 1'b1;
		@(posedge clk_i);
		re <= 1'b0;
		#1 chk(rdata & k, e, "register read");
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		addr <= a;
		wdata <= d;
		we <= 1'b1;
		@(posedge clk_i);
		we <= 1'b0;
		#1;
	endtask

	task pin_low(input logic [15:0] n);
		@(posedge clk_i);
		pulse <= 1'b1;
		len <= n;
		@(posedge clk_i);
		pulse <= 1'b0;
	endtask

	// Bounded wait; a miss shows up in the checks that follow.
	task wait_hi(input bit r);
		for (int j = 0; j < 3000; j++) begin
			@(posedge clk_i);
			#1;
			if ((r ? run : ph) === 1'b1) break;
		end
	endtask

	// Counts the clock cycles from one system tick to the next.
	task tick_gap(input logic [31:0] e, input string m);
		int n;
		n = 0;
		for (int j = 0; j < 100; j++) begin
			@(posedge clk_i);
			#1;
			if (tick === 1'b1) break;
		end
		for (int j = 0; j < 100; j++) begin
			@(posedge clk_i);
			#1;
			n++;
			if (tick === 1'b1) break;
		end
		chk(n, e, m);
	endtask

	task chk_state(input string m);
		chk({8'h00, pc}, {8'h00, VEC}, m);
		chk(sp, 32'h0000_0100, m);
		chk({25'h0, mask, mx, bank}, {25'h0, 3'h7, 1'b1, 3'h0}, m);
	endtask

	initial begin
		#300000;
		err_count++;
		stop_test;
	end

	initial begin
		rst_i = 1'b1;
		{pulse, we, re} = 3'h0;
		len = 16'h0000;
		addr = 8'h00;
		wdata = 32'h0000_0000;
		r_a = '{8'h00, 8'h08, 8'h0c, 8'h04, 8'h10};
		r_m = '{32'h0000_0007, 32'h00ff_ffff, 32'hffff_ffff, 32'h0000_7f07, 32'hffff_ffff};
		r_e = '{32'h4, {8'h00, VEC}, 32'h100, 32'h0f04, 32'h0};
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		#1 chk({29'h0, run, ale, ph}, 32'h0, "after reset");
		chk({29'h0, gear}, 32'h4, "gear");
		$display("test reset done");
		pin_low(16'd500);
		wait_hi(1'b0);
		chk({28'h0, ph, pm, ale, run}, 32'hc, "init");
		wait_hi(1'b1);
		chk({30'h0, fst, ale}, 32'h3, "release");
		chk_state("first run");
		tick_gap(32'h20, "slow tick");
		$display("test vector load done");
		for (i = 0; i < 5; i++) rd_chk(r_a[i], r_m[i], r_e[i]);
		$display("test register reads done");
		pin_low(16'd100);
		repeat (6) @(posedge clk_i);
		#1 chk({31'h0, run}, 32'h0, "held");
		wait_hi(1'b1);
		chk_state("short pulse");
		$display("test short pulse done");
		wr(8'h00, 32'h0);
		chk({29'h0, gear}, 32'h0, "gear write");
		wr(8'h00, 32'h7);
		chk({29'h0, gear}, 32'h0, "reserved gear");
		tick_gap(32'h2, "fast tick");
		pin_low(16'd100);
		wait_hi(1'b0);
		// The gear is forced on the edge after the vector phase starts.
		@(posedge clk_i);
		#1 chk({29'h0, gear}, 32'h4, "gear reload");
		wait_hi(1'b1);
		chk_state("fast gear run");
		$display("test gear reload done");
		stop_test;
	end
endmodule
